/* File: design/hspc_pkg.sv */
package hspc_pkg;
  // ****************************************
  // timing constants
  // ****************************************
  localparam int CLK_HZ = 40000000;  // core clock rate
  localparam int SW_DELAY_US = 300;  // longest software output delay
  // longest time rounds down, never below one cycle
  localparam int SW_DELAY_CYC_RAW = (SW_DELAY_US * (CLK_HZ / 1000000));
  localparam int SW_DELAY_CYC = (SW_DELAY_CYC_RAW < 1) ? 1 : SW_DELAY_CYC_RAW;
  localparam int INHIBIT_US = 100;  // least inhibit hold time at the pin
  localparam int INHIBIT_CYC = INHIBIT_US * (CLK_HZ / 1000000);
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;  // present value after reset
  localparam logic [15:0] LIMIT_RST = 16'hffff;       // 16-bit limit constant, not used; the 16-bit mode limit comes from buffer words two and three
  // ****************************************
  // modes
  // ****************************************
  typedef enum logic [1:0] {
    HSPC_DIR_HW = 2'b01,  // direction from phase a pin
    HSPC_DIR_SW = 2'b10   // direction from buffer word one
  } hspc_dir_t;
endpackage

/* File: design/hspc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// two-flop synchroniser for pin inputs
// ****************************************
module hspc_sync import hspc_pkg::*; #(
  parameter int WIDTH = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;  // first stage, read only by second stage
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;  // second stage
  logic [WIDTH-1:0] sync_next;

  // a synchroniser needs at least one bit to carry
  if (WIDTH < 1) begin : g_bad_width
    $error("synchroniser width below one");
  end

  // next values of both stages
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // register both stages
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

/* File: design/hspc_counter.sv */
// Contract
// R1: direction source picked by configuration
// R2: hardware direction follows phase a level
// R3: software direction follows buffer word one
// R4: 32-bit mode keeps full signed range
// R5: 16-bit mode counts zero to limit
// R6: hardware match output driven directly by logic
// R7: software match output within 300 us
// R8: source holds inhibit at least 100 us
// R9: match sets output, reset command clears
// R10: inhibit freezes present value; a preset edge still loads the preset value while inhibited
`timescale 1ns/1ps
`default_nettype none
module hspc_counter import hspc_pkg::*; #(
  parameter int SW_DELAY = SW_DELAY_CYC  // cycles before software output follows
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic phase_a_in,               // direction pin in hardware direction mode
  input wire logic phase_b_in,               // count pulse pin, rising edge counts
  input wire logic preset_in,                // load preset value
  input wire logic inhibit_in,               // count inhibit pin
  input wire logic dir_sel_sw_in,            // 1 selects software direction
  input wire logic width16_in,               // 1 selects 16-bit unsigned mode
  input wire logic [15:0] buffer_memory_word1_in,  // software direction word
  input wire logic [15:0] buffer_memory_word2_in,  // limit low half
  input wire logic [15:0] buffer_memory_word3_in,  // limit high half
  input wire logic [31:0] preset_value_in,   // value loaded on preset
  input wire logic [31:0] compare_value_in,  // match value
  input wire logic match_reset_in,           // reset command for match outputs
  output logic [31:0] count_out,             // present value
  output logic dir_down_out,                 // current direction
  output logic hardware_match_output,        // set on match
  output logic software_match_output         // delayed copy of match
);
  // ****************************************
  // elaboration check
  // ****************************************
  if (SW_DELAY < 1 || SW_DELAY > SW_DELAY_CYC) begin : g_bad_delay
    $error("software delay outside 1 to its longest value");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] pins_sync;  // b, a, preset, inhibit after two flops
  hspc_sync #(.WIDTH(4)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({phase_b_in, phase_a_in, preset_in, inhibit_in}),
    .sync_out(pins_sync)
  );
  logic a_s, b_s, pre_s, inh_s;
  assign b_s = pins_sync[3];
  assign a_s = pins_sync[2];
  assign pre_s = pins_sync[1];
  assign inh_s = pins_sync[0];

  // ****************************************
  // counter core
  // ****************************************
  logic [31:0] count_reg, count_next;  // present value
  logic b_old_reg, b_old_next;         // previous phase b for edge detect
  logic pre_old_reg, pre_old_next;     // previous preset for edge detect
  logic hm_reg, hm_next;               // hardware match flag
  hspc_dir_t dir_mode;                 // selected direction source
  logic down;                          // count down this cycle
  logic pulse;                         // rising edge on count input
  logic [31:0] limit;                  // 16-bit mode upper limit

  // direction source and the level it yields this cycle
  always_comb begin
    dir_mode = dir_sel_sw_in ? HSPC_DIR_SW : HSPC_DIR_HW;  // see R1
    unique case (dir_mode)
      HSPC_DIR_HW: down = a_s;                                // see R2
      HSPC_DIR_SW: down = (buffer_memory_word1_in != 16'h0000);  // see R3
    endcase
  end

  // next state of the counter and match flag
  always_comb begin
    limit = {buffer_memory_word3_in, buffer_memory_word2_in};  // see R5
    pulse = b_s && !b_old_reg;
    b_old_next = b_s;
    pre_old_next = pre_s;
    count_next = count_reg;
    hm_next = hm_reg;
    if (pre_s && !pre_old_reg) begin
      // preset edge loads the preset value
      count_next = preset_value_in;
    end else if (pulse && !inh_s) begin  // see R10
      if (width16_in) begin
        // unsigned ring from zero to limit
        if (down) begin
          count_next = (count_reg == 32'h0000_0000) ? limit : count_reg - 32'h0000_0001;  // see R5
        end else begin
          count_next = (count_reg >= limit) ? 32'h0000_0000 : count_reg + 32'h0000_0001;  // see R5
        end
      end else begin
        // signed wrap across the full range
        count_next = down ? count_reg - 32'h0000_0001 : count_reg + 32'h0000_0001;  // see R4
      end
    end
    if (count_reg == compare_value_in) begin
      hm_next = 1'b1;  // see R9
    end else if (match_reset_in) begin
      hm_next = 1'b0;  // see R9
    end
  end

  // register the counter core
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_reg <= COUNT_RST;
      b_old_reg <= 1'b0;
      pre_old_reg <= 1'b0;
      hm_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      b_old_reg <= b_old_next;
      pre_old_reg <= pre_old_next;
      hm_reg <= hm_next;
    end
  end

  // ****************************************
  // software match delay line
  // ****************************************
  logic [31:0] dly_reg, dly_next;  // cycles since hardware match set
  logic sm_reg, sm_next;           // software match flag

  always_comb begin
    dly_next = dly_reg;
    sm_next = sm_reg;
    if (!hm_next) begin
      // clear together with the hardware flag so software is never set without hardware
      dly_next = 32'h0000_0000;
      sm_next = 1'b0;
    end else if (dly_reg < 32'(SW_DELAY - 1)) begin
      dly_next = dly_reg + 32'h0000_0001;
    end else begin
      sm_next = 1'b1;  // see R7
    end
  end

  // register the delay line
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dly_reg <= 32'h0000_0000;
      sm_reg <= 1'b0;
    end else begin
      dly_reg <= dly_next;
      sm_reg <= sm_next;
    end
  end

  // ****************************************
  // helper logic for the delay assertion
  // ****************************************
  logic [31:0] sw_wait_reg, sw_wait_next;  // cycles with hardware match set, software not yet

  // counts while the software output lags, restarts otherwise
  always_comb begin
    sw_wait_next = 32'h0000_0000;
    if (hardware_match_output && !software_match_output) begin
      sw_wait_next = sw_wait_reg + 32'h0000_0001;
    end
  end

  // register the lag counter
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sw_wait_reg <= 32'h0000_0000;
    end else begin
      sw_wait_reg <= sw_wait_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign count_out = count_reg;
  assign dir_down_out = down;
  assign hardware_match_output = hm_reg;  // see R6
  assign software_match_output = sm_reg;

  // ****************************************
  // assertions
  // ****************************************
  // equality sets the hardware flag on the next edge
  hw_match_set_a: assert property (@(posedge clk_in) disable iff (rst_in)  // see R9
    (count_reg == compare_value_in) |=> hardware_match_output)
    else $error("hardware match not set on equality");
  // only a reset command may drop the hardware flag
  hw_match_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)  // see R9
    (hardware_match_output && !match_reset_in) |=> hardware_match_output)
    else $error("hardware match dropped without reset");
  // software flag lags the hardware flag by a bounded count
  sw_delay_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)  // see R7
    (hardware_match_output && !software_match_output)
      |-> (sw_wait_reg < 32'(SW_DELAY)))
    else $error("software match too late");
  sw_follow_a: assert property (@(posedge clk_in) disable iff (rst_in)  // see R7
    software_match_output |-> hardware_match_output)
    else $error("software match without hardware match");
  inhibit_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)  // see R10
    (inh_s && !(pre_s && !pre_old_reg)) |=> $stable(count_reg))
    else $error("count moved while inhibited");
  hw_dir_a: assert property (@(posedge clk_in) disable iff (rst_in)  // see R2
    (!dir_sel_sw_in) |-> (dir_down_out == a_s))
    else $error("hardware direction wrong");
  sw_dir_a: assert property (@(posedge clk_in) disable iff (rst_in)  // see R3
    dir_sel_sw_in |-> (dir_down_out == (buffer_memory_word1_in != 16'h0000)))
    else $error("software direction wrong");
  up16_wrap_a: assert property (@(posedge clk_in) disable iff (rst_in)  // see R5
    (width16_in && pulse && !inh_s && !down && !(pre_s && !pre_old_reg)
      && count_reg >= limit) |=> (count_reg == 32'h0000_0000))
    else $error("16-bit count did not wrap at limit");
  up32_step_a: assert property (@(posedge clk_in) disable iff (rst_in)  // see R4
    (!width16_in && pulse && !inh_s && !down && !(pre_s && !pre_old_reg))
      |=> (count_reg == $past(count_reg) + 32'h0000_0001))
    else $error("32-bit count did not step up");
  // ****************************************
  // covers of the main scenarios
  // ****************************************
  cnt_up_c: cover property (@(posedge clk_in) disable iff (rst_in) pulse && !down);
  cnt_dn_c: cover property (@(posedge clk_in) disable iff (rst_in) pulse && down);
  match_c: cover property (@(posedge clk_in) disable iff (rst_in) $rose(software_match_output));
  inhibit_c: cover property (@(posedge clk_in) disable iff (rst_in) pulse && inh_s);
endmodule
`default_nettype wire

/* File: test/hspc_src.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// pulse source model
// ****
module hspc_src import hspc_pkg::*; (
  input wire logic clk_in,
  output logic phase_b_out,  // count pulse pin
  output logic inhibit_out   // count inhibit pin
);
  initial begin
    phase_b_out = 1'b0;
    inhibit_out = 1'b0;
  end
  // pulses three cycles high, three low
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge clk_in) phase_b_out = 1'b1;
      repeat (3) @(negedge clk_in);
      phase_b_out = 1'b0;
      repeat (2) @(negedge clk_in);
    end
  endtask
  // inhibit held past its least time, pulses sent inside it
  task automatic inhibited(input int n);
    @(negedge clk_in) inhibit_out = 1'b1;
    repeat (8) @(negedge clk_in);
    pulse(n);
    repeat (INHIBIT_CYC) @(negedge clk_in);
    inhibit_out = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: test/tb_high_speed_pulse_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_high_speed_pulse_counter import hspc_pkg::*;;
  localparam int SWD = 4;  // short software output delay
  logic clk_in = 1'b0;
  logic rst_in, ph_a, ph_b, pre, inh, dsw, w16, mrst;
  logic [15:0] w1, w2, w3;
  logic [31:0] pval, cval, cnt;
  logic dn, hwm, swm;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  always #12.5 clk_in = ~clk_in;
  hspc_src i_src (.clk_in(clk_in), .phase_b_out(ph_b), .inhibit_out(inh));
  hspc_counter #(.SW_DELAY(SWD)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .phase_a_in(ph_a), .phase_b_in(ph_b), .preset_in(pre), .inhibit_in(inh),
    .dir_sel_sw_in(dsw), .width16_in(w16), .buffer_memory_word1_in(w1),
    .buffer_memory_word2_in(w2), .buffer_memory_word3_in(w3),
    .preset_value_in(pval), .compare_value_in(cval), .match_reset_in(mrst),
    .count_out(cnt), .dir_down_out(dn), .hardware_match_output(hwm),
    .software_match_output(swm));
  // ****
  // helpers
  // ****
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // loads a value through the preset pin
  task automatic load(input logic [31:0] v);
    pval = v;
    @(negedge clk_in) pre = 1'b1;
    repeat (3) @(negedge clk_in);
    pre = 1'b0;
    repeat (6) @(negedge clk_in);
  endtask
  // sets the direction pin and lets it cross the synchroniser
  task automatic dir_pin(input logic v);
    ph_a = v;
    repeat (4) @(negedge clk_in);
  endtask
  // applies mode inputs, buffer words, compare value and reset command
  task automatic cfg(input logic sw, input logic wide16, input logic [15:0] d1,
      input logic [15:0] lo, input logic [15:0] hi, input logic [31:0] cmp,
      input logic clr);
    dsw = sw;
    w16 = wide16;
    w1 = d1;
    w2 = lo;
    w3 = hi;
    cval = cmp;
    mrst = clr;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_dir();
    load(32'h0);
    i_src.pulse(5);
    chk("hw up", 32'h5, cnt);
    dir_pin(1'b1);
    chk("hw dir", 32'h1, {31'h0, dn});
    i_src.pulse(2);
    chk("hw down", 32'h3, cnt);
    cfg(1'b1, 1'b0, 16'h0000, 16'h0000, 16'h0000, 32'hffff_0000, 1'b0);
    load(32'ha);
    chk("sw dir up", 32'h0, {31'h0, dn});
    i_src.pulse(2);
    chk("sw up", 32'hc, cnt);
    cfg(1'b1, 1'b0, 16'h0001, 16'h0000, 16'h0000, 32'hffff_0000, 1'b0);
    i_src.pulse(3);
    chk("sw down", 32'h9, cnt);
    chk("sw dir down", 32'h1, {31'h0, dn});
    cfg(1'b0, 1'b0, 16'h0001, 16'h0000, 16'h0000, 32'hffff_0000, 1'b0);
  endtask
  task automatic t_width();
    load(32'h0);
    i_src.pulse(1);
    chk("signed under", 32'hffff_ffff, cnt);
    dir_pin(1'b0);
    load(32'h7fff_ffff);
    i_src.pulse(1);
    chk("signed over", 32'h8000_0000, cnt);
    cfg(1'b0, 1'b1, 16'h0000, 16'h0003, 16'h0000, 32'hffff_0000, 1'b0);
    load(32'h2);
    i_src.pulse(2);
    chk("limit wrap", 32'h0, cnt);
    dir_pin(1'b1);
    i_src.pulse(1);
    chk("zero wrap", 32'h3, cnt);
    cfg(1'b0, 1'b0, 16'h0000, 16'h0003, 16'h0000, 32'hffff_0000, 1'b0);
    dir_pin(1'b0);
  endtask
  task automatic t_match();
    cfg(1'b0, 1'b0, 16'h0000, 16'h0003, 16'h0000, 32'h0000_0010, 1'b0);
    load(32'he);
    i_src.pulse(2);
    chk("hw match", 32'h1, {31'h0, hwm});
    repeat (SWD + 2) @(negedge clk_in);
    chk("sw match", 32'h1, {31'h0, swm});
    i_src.pulse(1);
    chk("match held", 32'h1, {31'h0, hwm});
    cfg(1'b0, 1'b0, 16'h0000, 16'h0003, 16'h0000, 32'h0000_0010, 1'b1);
    repeat (2) @(negedge clk_in);
    cfg(1'b0, 1'b0, 16'h0000, 16'h0003, 16'h0000, 32'h0000_0010, 1'b0);
    repeat (SWD + 2) @(negedge clk_in);
    chk("hw cleared", 32'h0, {31'h0, hwm});
    chk("sw cleared", 32'h0, {31'h0, swm});
  endtask
  task automatic t_inhibit();
    load(32'h5);
    i_src.inhibited(4);
    chk("inhibit hold", 32'h5, cnt);
    repeat (4) @(negedge clk_in);
    i_src.pulse(1);
    chk("after inhibit", 32'h6, cnt);
  endtask
  // ****
  // timeout and main sequence
  // ****
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    rst_in = 1'b1;
    {ph_a, pre} = 2'h0;
    cfg(1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000, 32'hffff_0000, 1'b0);
    pval = 32'h0;
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    t_dir();
    t_width();
    t_match();
    t_inhibit();
    stop_test();
  end
endmodule
`default_nettype wire
